/* cbd_cfg.svh */
// Constants for branch decode and instruction cycle timing
`ifndef CBD_CFG_SVH
`define CBD_CFG_SVH

// ----------------------------------------
// Cycle timing
// ----------------------------------------
`define CBD_CYCLE_CLOCKS 4
`define CBD_LAST_PHASE 2'h3
`define CBD_PRESCALE_SLOW 4'hC
`define CBD_PRESCALE_FAST 2'h3
`define CBD_XMOVE_BASE 4'h2

// ----------------------------------------
// Clock stretch control register
// ----------------------------------------
`define CBD_STRETCH_ADDR 8'h8E
`define CBD_STRETCH_RESET 8'h01
`define CBD_STRETCH_MASK 8'h3F
`define CBD_MD_MSB 2
`define CBD_T0M_BIT 3
`define CBD_T1M_BIT 4
`define CBD_T2M_BIT 5

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define CBD_OP_NO_OP 8'h00
`define CBD_OP_RSVD_NO_OP 8'hA5
`define CBD_ABS_CALL_LOW 5'h11
`define CBD_ABS_JUMP_LOW 5'h01
`define CBD_OP_LONG_CALL 8'h12
`define CBD_OP_LONG_JUMP 8'h02
`define CBD_OP_SUB_RETURN 8'h22
`define CBD_OP_INT_RETURN 8'h32
`define CBD_OP_SHORT_JUMP 8'h80
`define CBD_OP_JC 8'h40
`define CBD_OP_JNC 8'h50
`define CBD_OP_JZ 8'h60
`define CBD_OP_JNZ 8'h70
`define CBD_OP_JBIT 8'h20
`define CBD_OP_JNBIT 8'h30
`define CBD_OP_JBIT_CLEAR 8'h10
`define CBD_OP_IND_JUMP 8'h73
`define CBD_OP_CMP_ACC_IMM 8'hB4
`define CBD_OP_CMP_ACC_DIR 8'hB5
`define CBD_OP_CMP_IND_HI7 7'h5B
`define CBD_OP_CMP_REG_HI5 5'h17
`define CBD_OP_DEC_REG_HI5 5'h1B
`define CBD_OP_DEC_DIR 8'hD5
`define CBD_OP_MOV_DIR_DIR 8'h85
`define CBD_OP_MOV_DIR_IMM 8'h75
`define CBD_OP_MOV_PTR_IMM 8'h90
`define CBD_OP_MULTIPLY 8'hA4
`define CBD_OP_DIVIDE 8'h84
`define CBD_OP_XMOV_PTR_RD 8'hE0
`define CBD_OP_XMOV_PTR_WR 8'hF0
`define CBD_OP_XMOV_RI_RD7 7'h71
`define CBD_OP_XMOV_RI_WR7 7'h79

`endif

/* cbd_pkg.sv */
// Types shared by the branch decode and timing modules
`default_nettype none
package cbd_pkg;
  // Instruction class after decode
  typedef enum logic [3:0] {
    K_PLAIN, K_ABS_CALL, K_ABS_JUMP, K_LONG, K_REL, K_BIT_REL, K_CMP, K_DEC,
    K_SUB_RET, K_INT_RET, K_IND_JUMP, K_XMOVE
  } cbd_kind_e;

  // Decode result: byte length, instruction cycles, class
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] cycles;
    cbd_kind_e kind;
  } cbd_decode_s;

  // Phase generator state
  typedef struct packed {
    logic [1:0] phase;
  } cbd_phase_s;

  // Timer prescaler state
  typedef struct packed {
    logic [3:0] slowCnt;
    logic [1:0] fastCnt;
    logic tickSlow;
    logic tickFast;
  } cbd_presc_s;

  // Sequencer state
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [3:0] idx;
    logic [1:0] len;
    logic [3:0] cycles;
    cbd_kind_e kind;
    logic [7:0] stretch;
    logic instrDone;
    logic clearBit;
    logic releasePriority;
  } cbd_seq_s;
endpackage
`default_nettype wire

/* cbd_phase_gen.sv */
// Four-clock instruction cycle phase generator
`include "cbd_cfg.svh"
`default_nettype none
module cbd_phase_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic [1:0] phase,
  output logic cycleEnd
);
  import cbd_pkg::*;

  cbd_phase_s st; // Registered state
  cbd_phase_s next_st; // Next state

  // ----------------------------------------
  // Phase counter
  // ----------------------------------------
  // Wraps after the last phase so every cycle spans four clocks
  always_comb begin
    next_st = st;
    next_st.phase = st.phase + 2'h1;
  end

  // Register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign phase = st.phase;
  assign cycleEnd = (st.phase == `CBD_LAST_PHASE);

  cycle_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cycleEnd |=> !cycleEnd [*3] ##1 cycleEnd)
    else $error("instruction cycle is not four clocks");
endmodule
`default_nettype wire

/* cbd_timer_prescale.sv */
// Timer increment prescaler: one tick per twelve or per four clocks
`include "cbd_cfg.svh"
`default_nettype none
module cbd_timer_prescale (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic tickSlow,
  output logic tickFast
);
  import cbd_pkg::*;

  cbd_presc_s st; // Registered state
  cbd_presc_s next_st; // Next state

  // ----------------------------------------
  // Free-running dividers
  // ----------------------------------------
  // Both run always; the selector picks per timer, so switching is glitch free
  always_comb begin
    next_st = st;
    next_st.tickSlow = (st.slowCnt == (`CBD_PRESCALE_SLOW - 4'h2));
    next_st.slowCnt = next_st.tickSlow ? 4'hF : st.slowCnt + 4'h1;
    if (st.slowCnt == 4'hF) begin
      next_st.slowCnt = 4'h0;
    end
    next_st.tickFast = (st.fastCnt == (`CBD_PRESCALE_FAST - 2'h1));
    next_st.fastCnt = st.fastCnt + 2'h1;
  end

  // Register with synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tickSlow = st.tickSlow;
  assign tickFast = st.tickFast;

  slow_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tickSlow |-> ##12 tickSlow)
    else $error("slow timer tick is not every twelve clocks");
  fast_period_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tickFast |=> !tickFast [*3] ##1 tickFast)
    else $error("fast timer tick is not every four clocks");
endmodule
`default_nettype wire

/* cbd_branch_decode.sv */
// Branch decode, instruction sequencing and cycle timing for the core
//
// Functional notes
// - Instruction cycle is four system clocks.
// - Instructions other than external moves take one to five cycles.
// - External move takes two plus stretch field.
// - Absolute call: x1 pages, two bytes, three cycles.
// - Long call 12: three bytes, four cycles.
// - Short jump 80: two bytes, three cycles.
// - Bit jump-clear 10: three bytes, clears bit when the branch is taken.
// - Pointer jump 73: one byte, three cycles.
// - Compare direct B5: three bytes, four cycles.
// - Compare register B8-BF: three bytes, four cycles.
// - Compare indirect B6-B7: three bytes, four cycles.
// - Decrement register D8-DF: two bytes, three cycles.
// - Opcode A5 behaves as no-operation.
// - Direct move three cycles; pointer load 90 also three.
// - One fetch per byte; multiply takes longer.
// - Timers tick per twelve or four clocks.
`include "cbd_cfg.svh"
`default_nettype none
module cbd_branch_decode (
  input wire logic clk_sys,
  input wire logic rst_n,
  // Program memory fetch
  output logic [15:0] progAddr,
  output logic progRead,
  input wire logic [7:0] progData,
  // Special register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWrData,
  output logic [7:0] sfrRdData,
  // Condition inputs from the datapath
  input wire logic carryFlag,
  input wire logic accZero,
  input wire logic bitValue,
  input wire logic compareUnequal,
  input wire logic decNonZero,
  input wire logic [7:0] accValue,
  input wire logic [15:0] dataPointer,
  input wire logic [15:0] returnAddr,
  // Sequencing results
  output logic [7:0] opcode,
  output logic instrDone,
  output logic clearBit,
  output logic releasePriority,
  output logic externalDataMove,
  output logic [2:0] timerTick
);
  import cbd_pkg::*;

  cbd_seq_s st; // Registered state
  cbd_seq_s next_st; // Next state
  logic [1:0] phase; // Clock within the instruction cycle
  logic cycleEnd; // Last clock of an instruction cycle
  logic tickSlow; // Twelve-clock timer tick
  logic tickFast; // Four-clock timer tick
  cbd_decode_s dec; // Decode of the byte on the fetch bus
  cbd_decode_s cur; // Decode in force this cycle
  logic fetching; // This instruction cycle reads a code byte
  logic lastCycle; // This instruction cycle finishes the instruction
  logic taken; // Branch condition holds
  logic [15:0] pcSeq; // Address of the following instruction
  logic [7:0] b1; // First operand byte as seen now
  logic [7:0] b2; // Second operand byte as seen now

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  cbd_phase_gen u_phase (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .phase(phase),
    .cycleEnd(cycleEnd)
  );

  cbd_timer_prescale u_presc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tickSlow(tickSlow),
    .tickFast(tickFast)
  );

  // ----------------------------------------
  // Opcode decode
  // ----------------------------------------
  // Length and cycle count per opcode; stretch feeds external moves.
  // Opcodes outside this block's tables default to one byte, one cycle.
  function automatic cbd_decode_s decode(input logic [7:0] op, input logic [2:0] md);
    cbd_decode_s d;
    d = '{len: 2'd1, cycles: 4'd1, kind: K_PLAIN};
    if (op[4:0] == `CBD_ABS_CALL_LOW) begin
      d = '{len: 2'd2, cycles: 4'd3, kind: K_ABS_CALL};
    end else if (op[4:0] == `CBD_ABS_JUMP_LOW) begin
      d = '{len: 2'd2, cycles: 4'd3, kind: K_ABS_JUMP};
    end else if (op[7:3] == `CBD_OP_CMP_REG_HI5) begin
      d = '{len: 2'd3, cycles: 4'd4, kind: K_CMP};
    end else if (op[7:1] == `CBD_OP_CMP_IND_HI7) begin
      d = '{len: 2'd3, cycles: 4'd4, kind: K_CMP};
    end else if (op[7:3] == `CBD_OP_DEC_REG_HI5) begin
      d = '{len: 2'd2, cycles: 4'd3, kind: K_DEC};
    end else if (op[7:1] == `CBD_OP_XMOV_RI_RD7 || op[7:1] == `CBD_OP_XMOV_RI_WR7 ||
                 op == `CBD_OP_XMOV_PTR_RD || op == `CBD_OP_XMOV_PTR_WR) begin
      d = '{len: 2'd1, cycles: `CBD_XMOVE_BASE + {1'b0, md}, kind: K_XMOVE};
    end else begin
      case (op)
        `CBD_OP_LONG_CALL, `CBD_OP_LONG_JUMP: begin
          d = '{len: 2'd3, cycles: 4'd4, kind: K_LONG};
        end
        `CBD_OP_SUB_RETURN: begin
          d = '{len: 2'd1, cycles: 4'd4, kind: K_SUB_RET};
        end
        `CBD_OP_INT_RETURN: begin
          d = '{len: 2'd1, cycles: 4'd4, kind: K_INT_RET};
        end
        `CBD_OP_SHORT_JUMP, `CBD_OP_JC, `CBD_OP_JNC, `CBD_OP_JZ, `CBD_OP_JNZ: begin
          d = '{len: 2'd2, cycles: 4'd3, kind: K_REL};
        end
        `CBD_OP_JBIT, `CBD_OP_JNBIT, `CBD_OP_JBIT_CLEAR: begin
          d = '{len: 2'd3, cycles: 4'd4, kind: K_BIT_REL};
        end
        `CBD_OP_IND_JUMP: begin
          d = '{len: 2'd1, cycles: 4'd3, kind: K_IND_JUMP};
        end
        `CBD_OP_CMP_ACC_DIR, `CBD_OP_CMP_ACC_IMM: begin
          d = '{len: 2'd3, cycles: 4'd4, kind: K_CMP};
        end
        `CBD_OP_DEC_DIR: begin
          d = '{len: 2'd3, cycles: 4'd4, kind: K_DEC};
        end
        `CBD_OP_MOV_DIR_DIR, `CBD_OP_MOV_DIR_IMM, `CBD_OP_MOV_PTR_IMM: begin
          d = '{len: 2'd3, cycles: 4'd3, kind: K_PLAIN};
        end
        `CBD_OP_MULTIPLY, `CBD_OP_DIVIDE: begin
          d = '{len: 2'd1, cycles: 4'd5, kind: K_PLAIN};
        end
        `CBD_OP_NO_OP, `CBD_OP_RSVD_NO_OP: begin
          d = '{len: 2'd1, cycles: 4'd1, kind: K_PLAIN};
        end
        default: begin
          d = '{len: 2'd1, cycles: 4'd1, kind: K_PLAIN};
        end
      endcase
    end
    return d;
  endfunction

  // Relative target: following address plus sign-extended offset
  function automatic logic [15:0] relTarget(input logic [15:0] base, input logic [7:0] off);
    return base + {{8{off[7]}}, off};
  endfunction

  // ----------------------------------------
  // Branch conditions
  // ----------------------------------------
  // Condition code lives in the opcode's high nibble for the plain jumps
  always_comb begin
    taken = 1'b0;
    case (st.kind)
      K_REL: begin
        case (st.opcode)
          `CBD_OP_JC: taken = carryFlag;
          `CBD_OP_JNC: taken = !carryFlag;
          `CBD_OP_JZ: taken = accZero;
          `CBD_OP_JNZ: taken = !accZero;
          default: taken = 1'b1; // Short jump always branches
        endcase
      end
      K_BIT_REL: begin
        taken = (st.opcode == `CBD_OP_JNBIT) ? !bitValue : bitValue;
      end
      K_CMP: taken = compareUnequal;
      K_DEC: taken = decNonZero;
      default: taken = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Fetch and completion qualifiers
  // ----------------------------------------
  // During the opcode cycle the stored decode is stale, so use the live one
  always_comb begin
    dec = decode(progData, st.stretch[`CBD_MD_MSB:0]);
    cur = (st.idx == 4'h0) ? dec : '{len: st.len, cycles: st.cycles, kind: st.kind};
    fetching = ({2'b00, cur.len} > st.idx);
    lastCycle = cycleEnd && ((st.idx + 4'h1) == cur.cycles);
    pcSeq = st.pc + ((cycleEnd && fetching) ? 16'h0001 : 16'h0000);
    b1 = (st.idx == 4'h1) ? progData : st.byte1;
    b2 = (st.idx == 4'h2) ? progData : st.byte2;
  end

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.instrDone = 1'b0;
    next_st.clearBit = 1'b0;
    next_st.releasePriority = 1'b0;
    // Register write; reserved top bits stay zero
    if (sfrWrite && sfrAddr == `CBD_STRETCH_ADDR) begin
      next_st.stretch = sfrWrData & `CBD_STRETCH_MASK;
    end
    if (cycleEnd) begin
      // One program-memory byte per fetching cycle
      if (fetching) begin
        next_st.pc = pcSeq;
        case (st.idx)
          4'h0: begin
            next_st.opcode = progData;
            next_st.len = dec.len;
            next_st.cycles = dec.cycles;
            next_st.kind = dec.kind;
          end
          4'h1: next_st.byte1 = progData;
          default: next_st.byte2 = progData;
        endcase
      end
      if (lastCycle) begin
        // Instruction ends; select the new program counter
        next_st.idx = 4'h0;
        next_st.instrDone = 1'b1;
        case (cur.kind)
          K_ABS_CALL, K_ABS_JUMP: begin
            next_st.pc = {pcSeq[15:11], st.opcode[7:5], b1};
          end
          K_LONG: begin
            next_st.pc = {b1, b2};
          end
          K_REL, K_DEC: begin
            // Offset is the last operand byte
            if (taken) begin
              next_st.pc = relTarget(pcSeq, (cur.len == 2'd3) ? b2 : b1);
            end
          end
          K_BIT_REL, K_CMP: begin
            if (taken) begin
              next_st.pc = relTarget(pcSeq, b2);
            end
            // Only the clear variant touches the bit, and only when branching
            next_st.clearBit = taken && (st.opcode == `CBD_OP_JBIT_CLEAR);
          end
          K_IND_JUMP: begin
            next_st.pc = dataPointer + {8'h00, accValue};
          end
          K_SUB_RET: begin
            next_st.pc = returnAddr;
          end
          K_INT_RET: begin
            next_st.pc = returnAddr;
            next_st.releasePriority = 1'b1;
          end
          default: begin
            next_st.pc = pcSeq; // No-operation and plain ops just advance
          end
        endcase
      end else begin
        next_st.idx = st.idx + 4'h1;
      end
    end
  end

  // Register with synchronous reset; stretch defaults to three-cycle moves
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st <= '0;
      st.stretch <= `CBD_STRETCH_RESET;
      st.kind <= K_PLAIN;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Fetch strobe is combinational so the address and strobe share phase 0
  assign progAddr = st.pc;
  assign progRead = (phase == 2'h0) && fetching;
  assign sfrRdData = (sfrAddr == `CBD_STRETCH_ADDR) ? st.stretch : 8'h00;
  assign opcode = st.opcode;
  assign instrDone = st.instrDone;
  assign clearBit = st.clearBit;
  assign releasePriority = st.releasePriority;
  assign externalDataMove = (st.idx != 4'h0) && (st.kind == K_XMOVE);
  // Per-timer rate select: a set mode bit picks the four-clock rate
  assign timerTick[0] = st.stretch[`CBD_T0M_BIT] ? tickFast : tickSlow;
  assign timerTick[1] = st.stretch[`CBD_T1M_BIT] ? tickFast : tickSlow;
  assign timerTick[2] = st.stretch[`CBD_T2M_BIT] ? tickFast : tickSlow;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Clocks since the instruction began, for length checks only
  logic [5:0] clkCount;
  // Starts at zero so the first instruction after reset counts like the rest
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clkCount <= 6'h00;
    end else if (st.instrDone) begin
      clkCount <= 6'h01;
    end else begin
      clkCount <= clkCount + 6'h01;
    end
  end

  instr_length_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instrDone |-> clkCount == {st.cycles, 2'b00})
    else $error("instruction length is not four clocks per cycle");
  cycle_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instrDone && st.kind != K_XMOVE |-> st.cycles >= 4'd1 && st.cycles <= 4'd5)
    else $error("instruction cycle count out of range");
  xmove_length_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instrDone && st.kind == K_XMOVE
      |-> st.cycles == `CBD_XMOVE_BASE + {1'b0, st.stretch[`CBD_MD_MSB:0]})
    else $error("external move length does not follow stretch");
  abs_call_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cycleEnd && st.idx == 4'h0 && progData[4:0] == `CBD_ABS_CALL_LOW
      |=> st.len == 2'h2 && st.cycles == 4'h3)
    else $error("absolute call decode wrong");
  long_call_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cycleEnd && st.idx == 4'h0 && progData == `CBD_OP_LONG_CALL
      |=> st.len == 2'h3 && st.cycles == 4'h4)
    else $error("long call decode wrong");
  bit_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clearBit |-> instrDone && st.opcode == `CBD_OP_JBIT_CLEAR)
    else $error("bit cleared outside a taken jump-and-clear");
  reserved_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    cycleEnd && st.idx == 4'h0 && progData == `CBD_OP_RSVD_NO_OP
      |=> instrDone && st.pc == $past(st.pc) + 16'h0001)
    else $error("reserved opcode does not act as no-operation");
  short_jump_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    instrDone && st.opcode == `CBD_OP_SHORT_JUMP
      |-> st.pc == $past(st.pc) + {{8{st.byte1[7]}}, st.byte1})
    else $error("short jump target wrong");
  int_return_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    releasePriority |-> instrDone && st.kind == K_INT_RET && st.cycles == 4'd4)
    else $error("priority released outside interrupt return");
endmodule
`default_nettype wire

/* cbd_prog_mem.sv */
// Program memory model that answers the core's fetch strobe
`default_nettype none
module cbd_prog_mem (
  input wire logic clk_sys,
  input wire logic [15:0] progAddr,
  input wire logic progRead,
  input wire logic slow,
  output logic [7:0] progData,
  output int fetchCount
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Storage and fetch tracking
  // ----------------------------------------
  logic [7:0] mem [0:511]; // Code bytes, unloaded places hold no-operation
  logic [8:0] addr = 9'h000; // Address latched at the strobe
  int age = 9; // Clocks since the strobe, parked at 9
  logic [7:0] last = 8'h00; // Last byte shown
  logic shown; // Data lines carry the fetched byte
  initial begin
    fetchCount = 0;
    foreach (mem[i]) mem[i] = 8'h00;
  end
  // Slow mode shows the byte only in the sampling clock
  assign shown = (age <= 2) && (!slow || age == 2);
  // One access counted per strobe
  always @(posedge clk_sys) begin
    if (progRead === 1'b1) begin
      addr <= progAddr[8:0];
      age <= 0;
      fetchCount <= fetchCount + 1;
    end else if (age < 9) begin
      age <= age + 1;
    end
    if (shown) begin
      last <= progData;
    end
  end
  // Released lines show the inverse so a stale byte never passes
  always_comb begin
    if (shown) begin
      progData = mem[addr];
    end else begin
      progData = ~last;
    end
  end
endmodule
`default_nettype wire

/* cbd_branch_decode_bench.sv */
// Self-checking bench for branch decode and cycle timing
`include "cbd_cfg.svh"
`default_nettype none
module cbd_branch_decode_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] progAddr;
  logic progRead;
  logic [7:0] progData;
  logic [7:0] sfrAddr = `CBD_STRETCH_ADDR;
  logic sfrWrite = 1'b0;
  logic [7:0] sfrWrData = 8'h00;
  logic [7:0] sfrRdData;
  logic carryFlag = 1'b0, accZero = 1'b0, bitValue = 1'b0;
  logic compareUnequal = 1'b0, decNonZero = 1'b0;
  logic [7:0] accValue = 8'h10; // Fixed offset added to the pointer for the pointer jump
  logic [15:0] dataPointer = 16'h0050;
  logic [15:0] returnAddr = 16'h0000;
  logic [7:0] opcode;
  logic instrDone, clearBit, releasePriority, externalDataMove;
  logic [2:0] timerTick;
  logic slow = 1'b0; // Memory answers late
  int fetchCount;
  int num_errors = 0;
  int cmp_count = 0;
`define CBD_CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    num_errors++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end
  // Free-running system clock
  always #5 clk_sys = ~clk_sys;
  cbd_branch_decode i_cbd_branch_decode (.clk_sys(clk_sys), .rst_n(rst_n),
    .progAddr(progAddr), .progRead(progRead), .progData(progData), .sfrAddr(sfrAddr),
    .sfrWrite(sfrWrite), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
    .carryFlag(carryFlag), .accZero(accZero), .bitValue(bitValue),
    .compareUnequal(compareUnequal), .decNonZero(decNonZero), .accValue(accValue),
    .dataPointer(dataPointer), .returnAddr(returnAddr), .opcode(opcode),
    .instrDone(instrDone), .clearBit(clearBit), .releasePriority(releasePriority),
    .externalDataMove(externalDataMove), .timerTick(timerTick));
  cbd_prog_mem i_cbd_prog_mem (.clk_sys(clk_sys), .progAddr(progAddr),
    .progRead(progRead), .slow(slow), .progData(progData), .fetchCount(fetchCount));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Load code bytes in address order
  task automatic ld(input logic [15:0] a, input logic [7:0] b [$]);
    foreach (b[i]) i_cbd_prog_mem.mem[a + i] = b[i];
  endtask
  // One write strobe, read data visible on the next clock
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    sfrAddr = a;
    sfrWrData = d;
    sfrWrite = 1'b1;
    @(negedge clk_sys);
    sfrWrite = 1'b0;
  endtask
  // Read port is combinational
  task automatic sfr_read(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    sfrAddr = a;
    #1;
    `CBD_CHK(sfrRdData, e);
  endtask
  // Runs one instruction from one done pulse to the next; flg = {move, clear, release}
  task automatic run_step(input logic [1:0] len, input logic [3:0] cyc,
    input logic [15:0] pc, input logic [4:0] cond, input logic [8:0] wr,
    input logic [2:0] flg);
    int n;
    int xm;
    int f0;
    logic [15:0] a0;
    n = 0;
    xm = 0;
    f0 = fetchCount;
    a0 = progAddr;
    {carryFlag, accZero, bitValue, compareUnequal, decNonZero} = cond;
    if (wr[8]) begin
      sfrAddr = `CBD_STRETCH_ADDR;
      sfrWrData = wr[7:0];
      sfrWrite = 1'b1;
    end
    do begin
      @(negedge clk_sys);
      sfrWrite = 1'b0;
      n++;
      if (externalDataMove === 1'b1) xm++;
    end while (instrDone !== 1'b1 && n < 48);
    `CBD_CHK(n, 4 * cyc);
    `CBD_CHK(progAddr, pc);
    `CBD_CHK(progRead, 1'b1);
    `CBD_CHK(xm, flg[2] ? 4 * (cyc - 1) : 0);
    `CBD_CHK({clearBit, releasePriority}, flg[1:0]);
    `CBD_CHK(fetchCount - f0, int'(len));
    `CBD_CHK(opcode, i_cbd_prog_mem.mem[a0[8:0]]);
  endtask
  // Ticks per timer over 48 clocks, one expectation per timer
  task automatic count_ticks(input int e0, input int e1, input int e2);
    int c [3];
    int e [3];
    c = '{0, 0, 0};
    e = '{e0, e1, e2};
    repeat (48) begin
      @(negedge clk_sys);
      for (int i = 0; i < 3; i++) if (timerTick[i] === 1'b1) c[i]++;
    end
    for (int i = 0; i < 3; i++) `CBD_CHK(c[i], e[i]);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int k;
    // Loads wait past time zero so the model's own clearing cannot race them
    repeat (16) @(negedge clk_sys);
    ld(16'h0000, '{8'h00, 8'hA5, 8'h80, 8'h04});
    ld(16'h0008, '{8'h12, 8'h00, 8'h40});
    ld(16'h0040, '{8'h32});
    ld(16'h000B, '{8'h10, 8'h07, 8'hFD, 8'h73});
    ld(16'h0060, '{8'hB5, 8'h12, 8'h02});
    ld(16'h0065, '{8'hB8, 8'h00, 8'h05, 8'hB7, 8'h00, 8'h10});
    ld(16'h007B, '{8'hD9, 8'h02, 8'h00, 8'h00, 8'h31, 8'h00});
    ld(16'h0100, '{8'h22});
    ld(16'h0090, '{8'h85, 8'h01, 8'h02, 8'hE0, 8'hA4, 8'hF0, 8'h00, 8'hE2});
    ld(16'h0098, '{8'h40, 8'h02, 8'h00, 8'h00, 8'h70, 8'hFE, 8'h02, 8'h00, 8'h00});
    rst_n = 1'b1;
    sfr_read(`CBD_STRETCH_ADDR, 8'h01);
    for (k = 0; k < 20 && instrDone !== 1'b1; k++) @(negedge clk_sys);
    `CBD_CHK(progAddr, 16'h0001);
    run_step(2'd1, 4'd1, 16'h0002, 5'h00, 9'h000, 3'h0);
    run_step(2'd2, 4'd3, 16'h0008, 5'h00, 9'h000, 3'h0);
    run_step(2'd3, 4'd4, 16'h0040, 5'h00, 9'h000, 3'h0);
    returnAddr = 16'h000B;
    run_step(2'd1, 4'd4, 16'h000B, 5'h00, 9'h000, 3'h1);
    run_step(2'd3, 4'd4, 16'h000B, 5'h04, 9'h000, 3'h2);
    run_step(2'd3, 4'd4, 16'h000E, 5'h00, 9'h000, 3'h0);
    slow = 1'b1;
    run_step(2'd1, 4'd3, 16'h0060, 5'h00, 9'h000, 3'h0);
    run_step(2'd3, 4'd4, 16'h0065, 5'h02, 9'h000, 3'h0);
    run_step(2'd3, 4'd4, 16'h0068, 5'h00, 9'h000, 3'h0);
    run_step(2'd3, 4'd4, 16'h007B, 5'h02, 9'h000, 3'h0);
    run_step(2'd2, 4'd3, 16'h007F, 5'h01, 9'h000, 3'h0);
    run_step(2'd2, 4'd3, 16'h0100, 5'h00, 9'h000, 3'h0);
    returnAddr = 16'h0090;
    run_step(2'd1, 4'd4, 16'h0090, 5'h00, 9'h000, 3'h0);
    run_step(2'd3, 4'd3, 16'h0093, 5'h00, 9'h000, 3'h0);
    run_step(2'd1, 4'd3, 16'h0094, 5'h00, 9'h000, 3'h4);
    run_step(2'd1, 4'd5, 16'h0095, 5'h00, 9'h100, 3'h0);
    run_step(2'd1, 4'd2, 16'h0096, 5'h00, 9'h000, 3'h4);
    run_step(2'd1, 4'd1, 16'h0097, 5'h00, 9'h1FF, 3'h0);
    run_step(2'd1, 4'd9, 16'h0098, 5'h00, 9'h000, 3'h4);
    run_step(2'd2, 4'd3, 16'h009C, 5'h10, 9'h000, 3'h0);
    run_step(2'd2, 4'd3, 16'h009E, 5'h08, 9'h000, 3'h0);
    run_step(2'd3, 4'd4, 16'h0000, 5'h00, 9'h000, 3'h0);
    sfr_read(`CBD_STRETCH_ADDR, 8'h3F);
    sfr_write(8'h8F, 8'h55);
    sfr_read(8'h8F, 8'h00);
    sfr_read(`CBD_STRETCH_ADDR, 8'h3F);
    count_ticks(12, 12, 12);
    sfr_write(`CBD_STRETCH_ADDR, 8'h11);
    repeat (12) @(negedge clk_sys);
    count_ticks(4, 12, 4);
    stop_test();
  end
  // Watchdog well beyond the few hundred clocks the sequence needs
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
